// ### dv/dis_cf_model.sv
// Purpose: Behavioural controller/formatter and drive behind the core.
// Assumes: Commands arrive as one-cycle pulses on clk_sys.
// Notes:   stall withholds end signals so that the watchdogs expire.
`timescale 1ns/1ns
`default_nettype none
module dis_cf_model (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        stall,
	input  wire logic [43:0] syn_set,
	input  wire logic        io_cmd_issued,
	input  wire logic        seek_start,
	output logic [10:0]      syndrome_reg_zero,
	output logic [10:0]      syndrome_reg_one,
	output logic [10:0]      syndrome_reg_two,
	output logic [10:0]      syndrome_reg_three,
	output logic             io_end,
	output logic             seek_end,
	output logic             on_cylinder
);
	logic [2:0] io_cnt;
	logic [2:0] sk_cnt;
	// Status withheld while the heads move, until the seek count runs out
	assign on_cylinder = sk_cnt == 3'h0;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			{syndrome_reg_three, syndrome_reg_two, syndrome_reg_one,
				syndrome_reg_zero} <= 44'h00000000000;
			io_cnt <= 3'h0;
			sk_cnt <= 3'h0;
			io_end <= 1'b0;
			seek_end <= 1'b0;
		end else begin
			{syndrome_reg_three, syndrome_reg_two, syndrome_reg_one,
				syndrome_reg_zero} <= syn_set;
			if (io_cmd_issued)
				io_cnt <= 3'h3;
			else if (io_cnt > 3'h1 || (io_cnt == 3'h1 && !stall))
				io_cnt <= io_cnt - 3'h1;
			io_end <= io_cnt == 3'h1 && !stall && !io_cmd_issued;
			if (seek_start)
				sk_cnt <= 3'h6;
			else if (sk_cnt > 3'h1 || (sk_cnt == 3'h1 && !stall))
				sk_cnt <= sk_cnt - 3'h1;
			seek_end <= sk_cnt == 3'h1 && !stall && !seek_start;
		end
	end
endmodule : dis_cf_model
`default_nettype wire

// ### dv/tb_top.sv
// Purpose: Self-checking bench for the disk interface status/control core.
// Assumes: Watchdog limits shortened to LIM cycles.
// Notes:   Input answers are queued by the driver and checked by a monitor.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	localparam int unsigned LIM = 20;
	logic        clk_sys = 1'b0, rst_n = 1'b0, master_clear = 1'b0;
	logic        clear_iface = 1'b0, func_strobe = 1'b0, func_is_out = 1'b0;
	logic        func_alt = 1'b0, busy = 1'b0, cf_selected = 1'b0;
	logic        cf_release_req = 1'b0, lost_data_evt = 1'b0, stall = 1'b0;
	logic        ecc_err_evt = 1'b0, cmd_overrun_evt = 1'b0, attn_evt = 1'b0;
	logic        ecc_in_addr_field = 1'b0, io_cmd_issued = 1'b0;
	logic        unit_ready = 1'b1, seek_start = 1'b0, write_req = 1'b0;
	logic        xfer_start = 1'b0;
	logic [3:0]  func_code = 4'h0;
	logic [15:0] acc_out = 16'h0000;
	logic [2:0]  cf_status_hi = 3'h0;
	logic [7:0]  drive_fault_evt = 8'h00, ds1_evt = 8'h00;
	logic [43:0] syn_set = 44'h00000000000;
	logic [10:0] syndrome_reg_zero, syndrome_reg_one;
	logic [10:0] syndrome_reg_two, syndrome_reg_three;
	logic        io_end, on_cylinder, seek_end, func_accept, acc_in_valid;
	logic        address_field_error_flag, home_seek, chs_clear, attention;
	logic        offset_active, write_inhibit, file_select_load;
	logic [3:0]  head_offset_ctl;
	logic [15:0] acc_in;
	logic [17:0] cur_addr, xfer_first_addr;
	logic [12:0] file_select;
	int          n_mismatch = 0, checks = 0;
	logic [15:0] expq[$];
	logic [31:0] rs = 32'h00000062;

	always #5 clk_sys = ~clk_sys;

	dis_core #(.SEEK_LIMIT(LIM), .CU_LIMIT(LIM)) uut (
		.clk_sys, .rst_n, .master_clear, .clear_iface, .func_strobe,
		.func_is_out, .func_code, .func_alt, .acc_out, .busy, .cf_selected,
		.func_accept, .acc_in, .acc_in_valid, .syndrome_reg_zero,
		.syndrome_reg_one, .syndrome_reg_two, .syndrome_reg_three,
		.cf_release_req, .lost_data_evt, .ecc_err_evt, .ecc_in_addr_field,
		.cmd_overrun_evt, .cf_status_hi, .io_cmd_issued, .io_end,
		.drive_fault_evt, .ds1_evt, .attn_evt, .unit_ready, .on_cylinder,
		.seek_start, .seek_end, .write_req, .xfer_start,
		.address_field_error_flag, .home_seek, .chs_clear, .head_offset_ctl,
		.offset_active, .write_inhibit, .attention, .cur_addr,
		.xfer_first_addr, .file_select, .file_select_load);

	// A home seek moves the heads like any other seek and ends the same way
	dis_cf_model cf (.clk_sys, .rst_n, .stall, .syn_set, .io_cmd_issued,
		.seek_start(seek_start || home_seek), .syndrome_reg_zero,
		.syndrome_reg_one, .syndrome_reg_two,
		.syndrome_reg_three, .io_end, .seek_end, .on_cylinder);

	function automatic logic [31:0] xs();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction : xs

	function automatic logic [7:0] ecc(input logic [43:0] s);
		logic [10:0] p [4];
		for (int k = 0; k < 4; k++)
			p[k] = s[11*k +: 11];
		return {(p[1] | p[2] | p[3]) == 11'h000, p[0] == p[3], p[0] == p[2],
			p[0] == p[1], p[3] == 11'h000, p[2] == 11'h000,
			p[1] == 11'h000, p[0] == 11'h000};
	endfunction : ecc

	task automatic chk(input string nm, input logic [17:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(negedge clk_sys);
	endtask : tick

	task automatic pulse(ref logic s);
		s = 1'b1;
		tick(1);
		s = 1'b0;
	endtask : pulse

	task automatic fn(input logic o, input logic [3:0] c, input logic a,
		input logic [15:0] d, input logic ok);
		// Idle edge first, so back-to-back calls always drop the strobe between them
		tick(1);
		func_strobe = 1'b1;
		func_is_out = o;
		func_code = c;
		func_alt = a;
		acc_out = d;
		#1 chk("func_accept", 18'(func_accept), 18'(ok));
		tick(1);
		func_strobe = 1'b0;
	endtask : fn

	task automatic rd(input logic [3:0] c, input logic [7:0] e);
		expq.push_back({8'h00, e});
		fn(1'b0, c, 1'b0, 16'h0000, 1'b1);
	endtask : rd

	task automatic give_verdict();
		if (n_mismatch == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : give_verdict

	// Answers stand one cycle, so they are taken at the next falling edge
	always @(negedge clk_sys) begin
		if (acc_in_valid === 1'b1) begin
			if (expq.size() == 0)
				chk("acc_in_valid", 18'h00001, 18'h00000);
			else
				chk("acc_in", 18'(acc_in), 18'(expq.pop_front()));
		end
	end

	initial begin
		tick(12);
		rst_n = 1'b1;
		tick(1);
		cf_selected = 1'b1;
		fn(1'b1, 4'hD, 1'b0, 16'h1234, 1'b1);
		fn(1'b1, 4'hE, 1'b0, 16'hFF8B, 1'b1);
		chk("file_select_load", 18'(file_select_load), 18'h00001);
		chk("file_select", 18'(file_select), 18'h01FFB);
		chk("cur_addr", cur_addr, 18'h31234);
		pulse(master_clear);
		chk("cur_addr", cur_addr, 18'h01234);
		fn(1'b1, 4'hE, 1'b0, 16'h0002, 1'b1);
		chk("cur_addr", cur_addr, 18'h21234);
		pulse(clear_iface);
		chk("cur_addr", cur_addr, 18'h01234);
		pulse(xfer_start);
		chk("xfer_first_addr", xfer_first_addr, 18'h01234);
		fn(1'b1, 4'hC, 1'b1, 16'h3000, 1'b1);
		chk("head_offset_ctl", 18'(head_offset_ctl), 18'h00003);
		chk("write_inhibit", 18'(write_inhibit), 18'h00001);
		chk("offset_active", 18'(offset_active), 18'h00001);
		pulse(write_req);
		ds1_evt = 8'h42;
		tick(1);
		ds1_evt = 8'h00;
		rd(4'hE, 8'h43);
		fn(1'b1, 4'hC, 1'b0, 16'h0006, 1'b1);
		rd(4'hE, 8'h00);
		fn(1'b1, 4'hC, 1'b1, 16'h0FFF, 1'b1);
		chk("head_offset_ctl", 18'(head_offset_ctl), 18'h00000);
		fn(1'b1, 4'hC, 1'b1, 16'h5ABC, 1'b1);
		fn(1'b1, 4'hC, 1'b0, 16'h0008, 1'b1);
		chk("head_offset_ctl", 18'(head_offset_ctl), 18'h00000);
		fn(1'b1, 4'hC, 1'b1, 16'hF000, 1'b1);
		tick(3);
		chk("head_offset_ctl", 18'(head_offset_ctl), 18'h0000F);
		pulse(seek_start);
		chk("head_offset_ctl", 18'(head_offset_ctl), 18'h00000);
		busy = 1'b1;
		fn(1'b1, 4'hC, 1'b1, 16'h3000, 1'b0);
		fn(1'b1, 4'hD, 1'b0, 16'h7777, 1'b0);
		busy = 1'b0;
		cf_selected = 1'b0;
		fn(1'b0, 4'hC, 1'b0, 16'h0000, 1'b0);
		fn(1'b1, 4'hC, 1'b1, 16'h3000, 1'b0);
		cf_selected = 1'b1;
		chk("head_offset_ctl", 18'(head_offset_ctl), 18'h00000);
		chk("cur_addr", cur_addr, 18'h01234);
		pulse(attn_evt);
		chk("attention", 18'(attention), 18'h00001);
		fn(1'b1, 4'hC, 1'b0, 16'h0040, 1'b1);
		chk("attention", 18'(attention), 18'h00000);
		drive_fault_evt = 8'hA5;
		tick(1);
		drive_fault_evt = 8'h00;
		rd(4'hC, 8'hA5);
		rd(4'h9, 8'h31);
		rd(4'hE, 8'h20);
		fn(1'b1, 4'hC, 1'b0, 16'h0020, 1'b1);
		rd(4'h9, 8'h30);
		rd(4'hE, 8'h00);
		fn(1'b1, 4'hC, 1'b0, 16'h0010, 1'b1);
		rd(4'hC, 8'h00);
		stall = 1'b1;
		pulse(seek_start);
		tick(LIM + 5);
		rd(4'hC, 8'h02);
		fn(1'b1, 4'hC, 1'b0, 16'h0010, 1'b1);
		rd(4'hC, 8'h02);
		stall = 1'b0;
		fn(1'b1, 4'hC, 1'b0, 16'h0080, 1'b1);
		chk("home_seek", 18'(home_seek), 18'h00001);
		chk("chs_clear", 18'(chs_clear), 18'h00001);
		rd(4'hC, 8'h00);
		pulse(io_cmd_issued);
		tick(6);
		rd(4'hD, 8'h00);
		stall = 1'b1;
		pulse(io_cmd_issued);
		tick(LIM + 5);
		stall = 1'b0;
		cf_release_req = 1'b1;
		cf_status_hi = 3'h5;
		ecc_in_addr_field = 1'b1;
		lost_data_evt = 1'b1;
		ecc_err_evt = 1'b1;
		cmd_overrun_evt = 1'b1;
		tick(1);
		{lost_data_evt, ecc_err_evt, cmd_overrun_evt} = 3'h0;
		chk("addr_field_flag", 18'(address_field_error_flag), 18'h1);
		rd(4'hD, 8'hBF);
		fn(1'b1, 4'hC, 1'b0, 16'h0001, 1'b1);
		rd(4'hD, 8'hA1);
		fn(1'b1, 4'hC, 1'b0, 16'h0004, 1'b1);
		rd(4'hD, 8'hA1);
		for (int i = 0; i < 8; i++) begin
			syn_set = 44'({xs(), xs()});
			if (i[0])
				syn_set[21:11] = syn_set[10:0];
			if (i[1])
				syn_set[32:22] = syn_set[10:0];
			if (i[2])
				syn_set[43:33] = syn_set[10:0];
			if (i == 5)
				syn_set[43:11] = 33'h000000000;
			if (i == 0)
				syn_set = 44'h00000000000;
			tick(1);
			rd(4'hB, ecc(syn_set));
		end
		tick(3);
		chk("pending answers", 18'(expq.size()), 18'h00000);
		give_verdict();
	end

	initial begin
		repeat (100000) @(posedge clk_sys);
		n_mismatch++;
		give_verdict();
	end
endmodule : tb_top
`default_nettype wire

// ### inc/dis_pkg.sv
// Purpose: Shared constants for the disk interface status/control block.
// Assumes: 100 MHz system clock; function codes as issued by the CPU.
// Notes:   Times are kept in their own unit; cycle counts derive from them.
package dis_pkg;

	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned NS_PER_MS     = 1000000;

	// Watchdog times
	localparam int unsigned SEEK_LIMIT_MS = 500;
	localparam int unsigned CU_LIMIT_MS   = 50;
	localparam int unsigned SEEK_LIMIT_CYC =
		SEEK_LIMIT_MS * NS_PER_MS / CLK_PERIOD_NS;
	localparam int unsigned CU_LIMIT_CYC =
		CU_LIMIT_MS * NS_PER_MS / CLK_PERIOD_NS;

	// Function codes (the alternate form is flagged by func_alt)
	localparam logic [3:0] FC_DS2      = 4'h9;
	localparam logic [3:0] FC_ECC_COND = 4'hB;
	localparam logic [3:0] FC_STATUS   = 4'hC;
	localparam logic [3:0] FC_ADDR_LO  = 4'hD;
	localparam logic [3:0] FC_ADDR_HI  = 4'hE;

	// Status control bit positions
	localparam int unsigned SC_CLR_CU    = 0;
	localparam int unsigned SC_CLR_DS1   = 1;
	localparam int unsigned SC_UNUSED    = 2;
	localparam int unsigned SC_CLR_REC   = 3;
	localparam int unsigned SC_CLR_FAULT = 4;
	localparam int unsigned SC_CLR_CHKF  = 5;
	localparam int unsigned SC_CLR_ATTN  = 6;
	localparam int unsigned SC_HOME      = 7;

	// Read recovery field
	localparam int unsigned REC_LSB = 12;
	localparam int unsigned REC_W   = 4;

	// Status word bit positions
	localparam int unsigned FW_SEEK_ERR  = 1;
	localparam int unsigned DS1_WR_OFS   = 0;
	localparam int unsigned DS1_CHKF     = 5;
	localparam int unsigned DS2_CHKF     = 0;
	localparam int unsigned DS2_OFS      = 1;
	localparam int unsigned DS2_READY    = 4;
	localparam int unsigned DS2_ONCYL    = 5;

	// Fault clear keeps the seek error; only a home seek drops it
	localparam logic [7:0] FW_CLR_MASK = 8'h02;
	localparam logic [7:0] RST_BYTE    = 8'h00;
	localparam logic [17:0] RST_ADDR   = 18'h00000;

	localparam int unsigned ADDR_W  = 18;
	localparam int unsigned SYN_W   = 11;
	localparam int unsigned FSEL_W  = 13;

endpackage : dis_pkg

// ### verilog/dis_core.sv
// Purpose: Function decode, status clearing and reporting, read recovery
//          and word address loading for the disk interface.
// Assumes: busy and cf_selected come from the transfer engine; drive and
//          controller events arrive as one-cycle pulses on clk_sys.
// Notes:   Input functions answer one cycle after acceptance.
// Summary of operation
// - ECC condition input returns syndrome comparison bits
// - Functions accepted only idle; all but address loads need controller selected
// - Status control bits clear controller and drive1
// - Bit 3 returns offset and strobe to normal
// - Bit 4 zeroes faults but the seek error, bit 5 check-fault
// - Bit 6 clears the attention bit
// - Bit 7 home seek, clears addresses and offset
// - Read recovery loads top nibble, ignores rest
// - Offset persists until recovery, clear, or seek
// - No writes while heads are offset
// - Fault input returns eight fault bits in order
// - Seek error on timeout; home seek clears
// - Address functions load low or upper bits
// - Transfer start uses current word address
// - Clears zero only upper two address bits
// - Upper address function feeds file selection
// - Controller bit 0 reports release request
// - Controller bit 1 reports lost data/parity
// - Controller bit 2 ECC; address field flag
// - Controller bit 3 on 50 ms end timeout
// - Controller bit 4 reports command overrun
`timescale 1ns/1ns
`default_nettype none
module dis_core #(
	parameter int unsigned SEEK_LIMIT = dis_pkg::SEEK_LIMIT_CYC,
	parameter int unsigned CU_LIMIT   = dis_pkg::CU_LIMIT_CYC
) (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        master_clear,
	input  wire logic        clear_iface,
	input  wire logic        func_strobe,
	input  wire logic        func_is_out,
	input  wire logic [3:0]  func_code,
	input  wire logic        func_alt,
	input  wire logic [15:0] acc_out,
	input  wire logic        busy,
	input  wire logic        cf_selected,
	output logic             func_accept,
	output logic [15:0]      acc_in,
	output logic             acc_in_valid,
	input  wire logic [10:0] syndrome_reg_zero,
	input  wire logic [10:0] syndrome_reg_one,
	input  wire logic [10:0] syndrome_reg_two,
	input  wire logic [10:0] syndrome_reg_three,
	input  wire logic        cf_release_req,
	input  wire logic        lost_data_evt,
	input  wire logic        ecc_err_evt,
	input  wire logic        ecc_in_addr_field,
	input  wire logic        cmd_overrun_evt,
	input  wire logic [2:0]  cf_status_hi,
	input  wire logic        io_cmd_issued,
	input  wire logic        io_end,
	input  wire logic [7:0]  drive_fault_evt,
	input  wire logic [7:0]  ds1_evt,
	input  wire logic        attn_evt,
	input  wire logic        unit_ready,
	input  wire logic        on_cylinder,
	input  wire logic        seek_start,
	input  wire logic        seek_end,
	input  wire logic        write_req,
	input  wire logic        xfer_start,
	output logic             address_field_error_flag,
	output logic             home_seek,
	output logic             chs_clear,
	output logic [3:0]       head_offset_ctl,
	output logic             offset_active,
	output logic             write_inhibit,
	output logic             attention,
	output logic [17:0]      cur_addr,
	output logic [17:0]      xfer_first_addr,
	output logic [12:0]      file_select,
	output logic             file_select_load
);

	function automatic logic is_zero(input logic [10:0] v);
		return v == 11'h000;
	endfunction : is_zero

	// Decode
	wire is_sc_out   = func_is_out && !func_alt
		&& func_code == dis_pkg::FC_STATUS;
	wire is_rec_out  = func_is_out && func_alt
		&& func_code == dis_pkg::FC_STATUS;
	wire is_lo_out   = func_is_out && !func_alt
		&& func_code == dis_pkg::FC_ADDR_LO;
	wire is_hi_out   = func_is_out && !func_alt
		&& func_code == dis_pkg::FC_ADDR_HI;
	wire is_input    = !func_is_out && !func_alt;
	wire is_ecc_in   = is_input && func_code == dis_pkg::FC_ECC_COND;
	wire is_fault_in = is_input && func_code == dis_pkg::FC_STATUS;
	wire is_cu_in    = is_input && func_code == dis_pkg::FC_ADDR_LO;
	wire is_ds1_in   = is_input && func_code == dis_pkg::FC_ADDR_HI;
	wire is_ds2_in   = is_input && func_code == dis_pkg::FC_DS2;
	wire needs_sel   = is_sc_out || is_rec_out || is_ecc_in
		|| is_fault_in || is_cu_in || is_ds1_in || is_ds2_in;
	wire is_known    = needs_sel || is_lo_out || is_hi_out;

	// Address loads need only an idle interface
	assign func_accept = func_strobe && is_known && !busy
		&& (cf_selected || !needs_sel);

	wire       do_sc     = func_accept && is_sc_out;
	wire       clr_cu    = do_sc && acc_out[dis_pkg::SC_CLR_CU];
	wire       clr_ds1   = do_sc && acc_out[dis_pkg::SC_CLR_DS1];
	wire       clr_rec   = do_sc && acc_out[dis_pkg::SC_CLR_REC];
	wire       clr_fault = do_sc && acc_out[dis_pkg::SC_CLR_FAULT];
	wire       clr_chkf  = do_sc && acc_out[dis_pkg::SC_CLR_CHKF];
	wire       clr_attn  = do_sc && acc_out[dis_pkg::SC_CLR_ATTN];
	wire       go_home   = do_sc && acc_out[dis_pkg::SC_HOME];
	wire [3:0] rec_field = acc_out[dis_pkg::REC_LSB +: dis_pkg::REC_W];
	wire       do_rec    = func_accept && is_rec_out;
	wire       ld_lo     = func_accept && is_lo_out;
	wire       ld_hi     = func_accept && is_hi_out;

	// Syndrome comparison: zero tests, matches against register zero, then registers one to three all zero
	wire [7:0] ecc_cond = {
		is_zero(syndrome_reg_one | syndrome_reg_two | syndrome_reg_three),
		syndrome_reg_zero == syndrome_reg_three,
		syndrome_reg_zero == syndrome_reg_two,
		syndrome_reg_zero == syndrome_reg_one,
		is_zero(syndrome_reg_three),
		is_zero(syndrome_reg_two),
		is_zero(syndrome_reg_one),
		is_zero(syndrome_reg_zero)};

	// Watchdogs
	logic seek_run;
	logic seek_expired;
	logic cu_expired;

	dis_timeout #(.LIMIT(SEEK_LIMIT)) u_seek_wd (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.start   (seek_start || go_home),
		.stop    (seek_end),
		.running (seek_run),
		.expired (seek_expired)
	);

	dis_timeout #(.LIMIT(CU_LIMIT)) u_cu_wd (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.start   (io_cmd_issued),
		.stop    (io_end),
		.running (),
		.expired (cu_expired)
	);

	// Status storage; a new event always beats a clear in the same cycle
	logic [4:1] cu_sticky;
	logic [7:0] fault_word;
	logic [7:0] ds1_sticky;
	logic       check_fault;

	wire [4:1] cu_set = {cmd_overrun_evt, cu_expired,
		ecc_err_evt, lost_data_evt};
	wire [7:0] fault_set = drive_fault_evt
		| ({7'h00, seek_expired} << dis_pkg::FW_SEEK_ERR);
	wire       chkf_set  = |fault_set;
	wire       wr_ofs    = write_req && offset_active;
	wire [7:0] ds1_set   = ds1_evt | {7'h00, wr_ofs};
	wire [7:0] fault_keep = (clr_fault ? dis_pkg::FW_CLR_MASK : 8'hFF)
		& ~({7'h00, go_home} << dis_pkg::FW_SEEK_ERR);

	wire [7:0] next_fault_word = (fault_word & fault_keep) | fault_set;
	wire [4:1] next_cu_sticky  = (clr_cu ? 4'h0 : cu_sticky) | cu_set;
	wire [7:0] next_ds1 = (clr_ds1 ? 8'h00 : ds1_sticky) | ds1_set;
	wire       next_check_fault = (check_fault && !clr_chkf && !clr_ds1)
		|| chkf_set;

	wire [7:0] cu_word  = {cf_status_hi, cu_sticky,
		cf_release_req};
	wire [7:0] ds1_word = {ds1_sticky[7:6], check_fault, ds1_sticky[4:0]};
	wire [7:0] ds2_word = {2'b00, on_cylinder, unit_ready, 2'b00,
		offset_active, check_fault};

	wire [7:0] reply_byte =
		is_ecc_in   ? ecc_cond :
		is_fault_in ? fault_word :
		is_cu_in    ? cu_word :
		is_ds1_in   ? ds1_word :
		is_ds2_in   ? ds2_word : 8'h00;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cu_sticky   <= 4'h0;
			fault_word  <= dis_pkg::RST_BYTE;
			ds1_sticky  <= dis_pkg::RST_BYTE;
			check_fault <= 1'b0;
			attention   <= 1'b0;
			address_field_error_flag <= 1'b0;
		end else begin
			cu_sticky   <= next_cu_sticky;
			fault_word  <= next_fault_word;
			ds1_sticky  <= next_ds1;
			check_fault <= next_check_fault;
			attention   <= (attention && !clr_attn) || attn_evt;
			address_field_error_flag <= (address_field_error_flag
				&& !clr_cu) || (ecc_err_evt && ecc_in_addr_field);
		end
	end

	// Read recovery holds until replaced, cleared, or a seek starts
	wire rec_drop = clr_rec || go_home || seek_start;
	wire [3:0] next_offset = do_rec ? rec_field
		: (rec_drop ? 4'h0 : head_offset_ctl);

	assign offset_active = |head_offset_ctl;
	assign write_inhibit = offset_active;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			head_offset_ctl <= 4'h0;
			home_seek       <= 1'b0;
			chs_clear       <= 1'b0;
		end else begin
			head_offset_ctl <= next_offset;
			home_seek       <= go_home;
			chs_clear       <= go_home;
		end
	end

	// Word address; clears leave the low sixteen bits alone
	wire       addr_clr = master_clear || clear_iface;
	wire [1:0] next_hi  = addr_clr ? 2'b00
		: (ld_hi ? acc_out[1:0] : cur_addr[17:16]);
	wire [15:0] next_lo = ld_lo ? acc_out : cur_addr[15:0];

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cur_addr         <= dis_pkg::RST_ADDR;
			xfer_first_addr  <= dis_pkg::RST_ADDR;
			file_select      <= 13'h0000;
			file_select_load <= 1'b0;
		end else begin
			cur_addr <= {next_hi, next_lo};
			if (xfer_start)
				xfer_first_addr <= cur_addr;
			if (ld_hi)
				file_select <= {acc_out[15:7], acc_out[3:0]};
			file_select_load <= ld_hi;
		end
	end

	// Input answers
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			acc_in       <= 16'h0000;
			acc_in_valid <= 1'b0;
		end else begin
			acc_in_valid <= func_accept && is_input;
			if (func_accept && is_input)
				acc_in <= {8'h00, reply_byte};
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	chk_accept_gate: assert property (
		func_accept |-> !busy && (cf_selected || is_lo_out || is_hi_out))
		else $error("function accepted while busy or unselected");
	chk_ecc_reply: assert property (
		func_accept && is_ecc_in |=> acc_in_valid
			&& acc_in[7:0] == $past(ecc_cond) && acc_in[15:8] == 8'h00)
		else $error("ECC condition answer wrong");
	chk_fault_reply: assert property (
		func_accept && is_fault_in |=> acc_in[7:0] == $past(fault_word))
		else $error("fault word answer wrong");
	chk_cu_clear: assert property (
		clr_cu && cu_set == 4'h0 |=> cu_sticky == 4'h0)
		else $error("controller status not cleared");
	chk_rec_load: assert property (
		do_rec |=> head_offset_ctl == $past(rec_field))
		else $error("read recovery setting not loaded");
	chk_rec_clear: assert property (
		(clr_rec || seek_start) && !do_rec |=> !offset_active)
		else $error("offset survived a clear or seek");
	chk_home_seek: assert property (
		go_home |=> home_seek && chs_clear && !offset_active
			&& !fault_word[dis_pkg::FW_SEEK_ERR] ##1 !home_seek)
		else $error("home seek effects missing");
	chk_write_block: assert property (
		write_req && offset_active |=> ds1_sticky[dis_pkg::DS1_WR_OFS]
			&& $past(write_inhibit))
		else $error("write not blocked while offset");
	chk_addr_upper: assert property (
		addr_clr && !ld_lo |=> cur_addr[17:16] == 2'b00
			&& cur_addr[15:0] == $past(cur_addr[15:0]))
		else $error("clear touched low address bits");
	chk_addr_low: assert property (
		ld_lo |=> cur_addr[15:0] == $past(acc_out))
		else $error("low address not loaded");
	chk_refused_hold: assert property (
		func_strobe && !func_accept && !addr_clr && !seek_start
			|=> $stable(cur_addr) && $stable(head_offset_ctl))
		else $error("refused function changed state");
	chk_xfer_addr: assert property (
		xfer_start |=> xfer_first_addr == $past(cur_addr))
		else $error("transfer address not taken");
	chk_cu_timeout: assert property (
		cu_expired |=> cu_sticky[3])
		else $error("controller timeout not flagged");

	cov_home: cover property (go_home ##1 home_seek);
	cov_rec: cover property (do_rec && |rec_field);
	cov_reject: cover property (func_strobe && busy);
	cov_seek_err: cover property (seek_expired);

endmodule : dis_core
`default_nettype wire

// ### verilog/dis_timeout.sv
// Purpose: Restartable watchdog; pulses when a started wait runs too long.
// Assumes: start and stop are one-cycle pulses on clk_sys.
// Notes:   Start during a running wait restarts the count.
`timescale 1ns/1ns
`default_nettype none
module dis_timeout #(
	parameter int unsigned LIMIT = 4
) (
	input  wire logic clk_sys,
	input  wire logic rst_n,
	input  wire logic start,
	input  wire logic stop,
	output logic      running,
	output logic      expired
);

	logic [31:0] count;
	wire         at_limit = running && (count == LIMIT - 1);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			running <= 1'b0;
			count   <= 32'h00000000;
			expired <= 1'b0;
		end else begin
			expired <= at_limit && !stop && !start;
			if (start) begin
				running <= 1'b1;
				count   <= 32'h00000000;
			end else if (stop || at_limit) begin
				running <= 1'b0;
			end else if (running) begin
				count <= count + 32'h00000001;
			end
		end
	end

endmodule : dis_timeout
`default_nettype wire
